// ===== hdl/dtd_pkg.sv
package dtd_pkg;
   localparam int unsigned DTD_AW       = 6;
   localparam int unsigned DTD_DW       = 32;
   // register index; byte address is four times the index
   localparam logic [3:0]  IDX_NCTL     = 4'h0;
   localparam logic [3:0]  IDX_SHARED   = 4'h1;
   localparam logic [3:0]  IDX_WCTL     = 4'h2;
   localparam logic [3:0]  IDX_JOINT    = 4'h3;
   localparam logic [3:0]  IDX_NINIT    = 4'h4;
   localparam logic [3:0]  IDX_WINIT_LO = 4'h5;
   localparam logic [3:0]  IDX_WINIT_HI = 4'h6;
   localparam logic [3:0]  IDX_NCAP_LO  = 4'h7;
   localparam logic [3:0]  IDX_NCAP_HI  = 4'h8;
   localparam logic [3:0]  IDX_WCAP_LO  = 4'h9;
   localparam logic [3:0]  IDX_WCAP_HI  = 4'ha;
   // timer control fields (narrow and wide alike)
   localparam int          C_EN         = 7;
   localparam int          C_SINGLE     = 6;
   localparam int          C_TOUT       = 5;
   localparam int          C_CLK_HI     = 4;
   localparam int          C_CLK_LO     = 3;
   localparam int          C_CAPM       = 2;
   localparam int          C_CNTM       = 1;
   localparam int          C_ROUTE      = 0;
   // shared configuration fields
   localparam int          S_MODE       = 7;
   localparam int          S_SEL        = 6;
   localparam int          S_LOG_HI     = 5;
   localparam int          S_LOG_LO     = 4;
   localparam int          S_PP_HI      = 3;
   localparam int          S_PP_LO      = 2;
   localparam logic [1:0]  PP_CODE      = 2'h1;
   localparam logic [7:0]  SHARED_WMASK = 8'hfc;
   // joint control fields
   localparam int          J_WEN        = 7;
   localparam int          J_NEN        = 6;
   localparam int          J_SYNC       = 5;
   // bits kept through a stop-mode recovery
   localparam logic [7:0]  CTL_KEEP     = 8'h1c;
   localparam logic [7:0]  SHARED_KEEP  = 8'h30;
   localparam logic [2:0]  PRE_ONE      = 3'h1;
   localparam logic [7:0]  N_ONE        = 8'h01;
   localparam logic [15:0] W_ONE        = 16'h0001;

   typedef enum logic [1:0] {DIV1 = 2'b00, DIV2 = 2'b01, DIV4 = 2'b10, DIV8 = 2'b11} dtd_div_e;
   typedef enum logic [1:0] {LG_AND = 2'b00, LG_OR = 2'b01, LG_NOR = 2'b10, LG_NAND = 2'b11}
      dtd_logic_e;
   typedef enum logic [1:0] {ED_FALL = 2'b00, ED_RISE = 2'b01, ED_BOTH = 2'b10, ED_RSVD = 2'b11}
      dtd_edge_e;
   typedef enum logic {BUS_IDLE = 1'b0, BUS_ACK = 1'b1} dtd_bus_e;

   typedef struct packed {
      logic [7:0]  nctl;
      logic [7:0]  shared;
      logic [7:0]  wctl;
      logic        sync;
      logic [7:0]  ninit;
      logic [15:0] winit;
      logic [7:0]  ncap_lo;
      logic [7:0]  ncap_hi;
      logic [15:0] wcap;
   } dtd_regs_s;

   typedef struct packed {
      dtd_regs_s   r;
      logic [7:0]  ncnt;
      logic [15:0] wcnt;
      logic        nout;
      logic        wout;
      logic        wcap_done;
      logic [2:0]  pre;
      logic [2:0]  sa;
      logic [2:0]  sb;
      logic        sta;
      logic        stb;
      logic        din_prev;
      dtd_bus_e    bus;
      logic        waitreq;
      logic [7:0]  rdata;
      logic        p1;
      logic        p2;
      logic        p3;
      logic        nirq;
      logic        wirq;
   } dtd_state_s;

   localparam dtd_state_s DTD_STATE_RST = '{default: '0, bus: BUS_IDLE, waitreq: 1'b1};
endpackage : dtd_pkg

// ===== hdl/dtd_timer.sv
`timescale 1ns/1ns
module dtd_timer
   import dtd_pkg::*;
(
   input  wire logic               i_core_clk,
   input  wire logic               i_rst_n,
   input  wire logic               i_stop_recover,
   input  wire logic [DTD_AW-1:0]  i_avs_address,
   input  wire logic               i_avs_read,
   input  wire logic               i_avs_write,
   input  wire logic [DTD_DW-1:0]  i_avs_writedata,
   input  wire logic [3:0]         i_avs_byteenable,
   output logic      [DTD_DW-1:0]  o_avs_readdata,
   output logic                    o_avs_waitrequest,
   input  wire logic               i_first_comparator_pin,
   input  wire logic               i_port_two_pin_zero,
   input  wire logic [2:0]         i_port_latch,
   output logic                    o_first_timer_out_pin,
   output logic                    o_second_timer_out_pin,
   output logic                    o_third_timer_out_pin,
   output logic                    o_narrow_irq,
   output logic                    o_wide_irq
);

   dtd_state_s        q;
   dtd_state_s        n;
   logic [3:0]        widx;
   logic [7:0]        wd;
   logic [7:0]        rd;
   logic              take_wr;
   logic              demod;
   logic              pp;
   logic              din;
   logic              rise;
   logic              fall;
   logic              hit;
   logic              nstart;
   logic              wstart;
   logic              nrun;
   logic              wrun;
   logic              n_to;
   logic              n_cap;
   logic              w_to;
   logic              w_cap;
   logic              comb_out;

   // prescaler tap for a clock select code
   function automatic logic dtd_tick(input logic [1:0] sel, input logic [2:0] pre);
      case (dtd_div_e'(sel))
         DIV1:    dtd_tick = 1'b1;
         DIV2:    dtd_tick = pre[0];
         DIV4:    dtd_tick = &pre[1:0];
         default: dtd_tick = &pre;
      endcase
   endfunction : dtd_tick

   always_comb
   begin
      n        = q;
      n_to     = 1'b0;
      n_cap    = 1'b0;
      w_to     = 1'b0;
      w_cap    = 1'b0;
      widx     = i_avs_address[DTD_AW-1:2];
      wd       = i_avs_writedata[7:0];
      take_wr  = (q.bus == BUS_ACK) && i_avs_write && i_avs_byteenable[0];
      demod    = q.r.shared[S_MODE];
      pp       = (q.r.shared[S_PP_HI:S_PP_LO] == PP_CODE);
      n.pre    = q.pre + PRE_ONE;
      // input synchronisers, change taken once stages two and three agree
      n.sa     = {q.sa[1:0], i_first_comparator_pin};
      n.sb     = {q.sb[1:0], i_port_two_pin_zero};
      if (q.sa[1] == q.sa[2])
      begin
         n.sta = q.sa[2];
      end
      if (q.sb[1] == q.sb[2])
      begin
         n.stb = q.sb[2];
      end
      din        = q.r.shared[S_SEL] ? q.stb : q.sta;
      n.din_prev = din;
      rise       = din & ~q.din_prev;
      fall       = ~din & q.din_prev;
      case (dtd_edge_e'(q.r.shared[S_LOG_HI:S_LOG_LO]))
         ED_FALL: hit = fall;
         ED_RISE: hit = rise;
         ED_BOTH: hit = rise | fall;
         default: hit = 1'b0;
      endcase
      // read mux
      case (widx)
         IDX_NCTL:     rd = q.r.nctl;
         IDX_SHARED:   rd = q.r.shared;
         IDX_WCTL:     rd = q.r.wctl;
         IDX_JOINT:    rd = {q.r.wctl[C_EN], q.r.nctl[C_EN], q.r.sync, 5'h00};
         IDX_NINIT:    rd = q.r.ninit;
         IDX_WINIT_LO: rd = q.r.winit[7:0];
         IDX_WINIT_HI: rd = q.r.winit[15:8];
         IDX_NCAP_LO:  rd = q.r.ncap_lo;
         IDX_NCAP_HI:  rd = q.r.ncap_hi;
         IDX_WCAP_LO:  rd = q.r.wcap[7:0];
         IDX_WCAP_HI:  rd = q.r.wcap[15:8];
         default:      rd = 8'h00;
      endcase
      // bus handshake: request seen, one cycle later waitrequest drops
      case (q.bus)
         BUS_IDLE:
         begin
            if (i_avs_read || i_avs_write)
            begin
               n.bus     = BUS_ACK;
               n.waitreq = 1'b0;
               n.rdata   = rd;
            end
         end
         default:
         begin
            n.bus     = BUS_IDLE;
            n.waitreq = 1'b1;
         end
      endcase
      // register writes
      if (take_wr)
      begin
         case (widx)
            IDX_NCTL:     n.r.nctl = {wd[7:6], q.r.nctl[C_TOUT] & ~wd[C_TOUT], wd[4:0]};
            IDX_SHARED:   n.r.shared = wd & SHARED_WMASK;
            IDX_WCTL:     n.r.wctl = {wd[7:6], q.r.wctl[C_TOUT] & ~wd[C_TOUT], wd[4:0]};
            IDX_JOINT:
            begin
               n.r.wctl[C_EN] = wd[J_WEN];
               n.r.nctl[C_EN] = wd[J_NEN];
               n.r.sync       = wd[J_SYNC];
            end
            IDX_NINIT:    n.r.ninit = wd;
            IDX_WINIT_LO: n.r.winit[7:0] = wd;
            IDX_WINIT_HI: n.r.winit[15:8] = wd;
            default:      ;
         endcase
      end
      // start detection; a fresh start reloads the initial count
      nstart = ~q.r.nctl[C_EN] & n.r.nctl[C_EN];
      wstart = ~q.r.wctl[C_EN] & n.r.wctl[C_EN];
      if (n.r.sync && (nstart || wstart))
      begin
         n.r.nctl[C_EN] = 1'b1;
         n.r.wctl[C_EN] = 1'b1;
         nstart         = 1'b1;
         wstart         = 1'b1;
         n.pre          = 3'h0;
      end
      if (nstart)
      begin
         n.ncnt = n.r.ninit;
         n.nout = 1'b0;
      end
      if (wstart)
      begin
         n.wcnt      = n.r.winit;
         n.wout      = 1'b0;
         n.wcap_done = 1'b0;
      end
      // narrow counter
      nrun = q.r.nctl[C_EN] & n.r.nctl[C_EN];
      if (nrun)
      begin
         if (demod && hit)
         begin
            if (fall)
            begin
               n.r.ncap_lo = q.ncnt;
            end
            else
            begin
               n.r.ncap_hi = q.ncnt;
            end
            n.ncnt = q.r.ninit;
            n_cap  = 1'b1;
         end
         else if (dtd_tick(q.r.nctl[C_CLK_HI:C_CLK_LO], q.pre))
         begin
            if (q.ncnt == 8'h00)
            begin
               n_to = 1'b1;
            end
            else
            begin
               n.ncnt = q.ncnt - N_ONE;
            end
         end
      end
      // wide counter
      wrun = q.r.wctl[C_EN] & n.r.wctl[C_EN];
      if (wrun)
      begin
         if (demod && hit)
         begin
            if (!(q.r.wctl[C_SINGLE] && q.wcap_done))
            begin
               n.r.wcap    = q.wcnt;
               n.wcnt      = q.r.winit;
               n.wcap_done = 1'b1;
               w_cap       = 1'b1;
            end
         end
         else if (dtd_tick(q.r.wctl[C_CLK_HI:C_CLK_LO], q.pre))
         begin
            if (q.wcnt == 16'h0000)
            begin
               w_to = 1'b1;
            end
            else
            begin
               n.wcnt = q.wcnt - W_ONE;
            end
         end
      end
      // terminal count handling; hardware set wins over a same-cycle clear
      if (n_to)
      begin
         n.r.nctl[C_TOUT] = 1'b1;
         n.ncnt           = q.r.ninit;
         n.nout           = ~q.nout & ~demod;
         if (pp)
         begin
            n.r.nctl[C_EN] = 1'b0;
            n.r.wctl[C_EN] = 1'b1;
            n.wcnt         = n.r.winit;
            n.wcap_done    = 1'b0;
         end
         else if (!demod && q.r.nctl[C_SINGLE])
         begin
            n.r.nctl[C_EN] = 1'b0;
         end
      end
      if (w_to)
      begin
         n.r.wctl[C_TOUT] = 1'b1;
         n.wcnt           = q.r.winit;
         n.wout           = ~q.wout & ~demod;
         if (pp)
         begin
            n.r.wctl[C_EN] = 1'b0;
            n.r.nctl[C_EN] = 1'b1;
            n.ncnt         = n.r.ninit;
         end
         else if (!demod && q.r.wctl[C_SINGLE])
         begin
            n.r.wctl[C_EN] = 1'b0;
         end
      end
      n.nirq = (n_to & q.r.nctl[C_CNTM]) | (n_cap & q.r.nctl[C_CAPM]);
      n.wirq = (w_to & q.r.wctl[C_CNTM]) | (w_cap & q.r.wctl[C_CAPM]);
      // warm restart masks the control and shared registers to their retained fields; the other registers keep their values
      if (i_stop_recover)
      begin
         n.r.nctl   = q.r.nctl & CTL_KEEP;
         n.r.wctl   = q.r.wctl & CTL_KEEP;
         n.r.shared = q.r.shared & SHARED_KEEP;
         n.nout     = 1'b0;
         n.wout     = 1'b0;
         n.nirq     = 1'b0;
         n.wirq     = 1'b0;
      end
      case (dtd_logic_e'(n.r.shared[S_LOG_HI:S_LOG_LO]))
         LG_AND:  comb_out = n.nout & n.wout;
         LG_OR:   comb_out = n.nout | n.wout;
         LG_NOR:  comb_out = ~(n.nout | n.wout);
         default: comb_out = ~(n.nout & n.wout);
      endcase
      n.p1 = n.r.nctl[C_ROUTE] ? n.nout : i_port_latch[0];
      n.p2 = n.r.wctl[C_ROUTE] ? n.wout : i_port_latch[1];
      n.p3 = (!n.r.shared[S_MODE] && n.r.shared[S_SEL]) ? comb_out : i_port_latch[2];
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         q <= DTD_STATE_RST;
      end
      else
      begin
         q <= n;
      end
   end

   assign o_avs_readdata         = {24'h000000, q.rdata};
   assign o_avs_waitrequest      = q.waitreq;
   assign o_first_timer_out_pin  = q.p1;
   assign o_second_timer_out_pin = q.p2;
   assign o_third_timer_out_pin  = q.p3;
   assign o_narrow_irq           = q.nirq;
   assign o_wide_irq             = q.wirq;

   default clocking dtd_cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_rst_n);

   tout_set_a: assert property ((w_to && !i_stop_recover) |=> q.r.wctl[C_TOUT])
      else $error("wide timeout flag not set");
   tout_clear_a: assert property ((take_wr && widx == IDX_WCTL && wd[C_TOUT] && !w_to
      && !i_stop_recover) |=> !q.r.wctl[C_TOUT])
      else $error("wide timeout flag not cleared");
   single_stop_a: assert property ((w_to && !demod && !pp && q.r.wctl[C_SINGLE]
      && !i_stop_recover) |=> !q.r.wctl[C_EN])
      else $error("single pass did not stop");
   modulo_reload_a: assert property ((w_to && !demod && !pp && !q.r.wctl[C_SINGLE]
      && !take_wr && !i_stop_recover) |=> (q.r.wctl[C_EN] && q.wcnt == $past(q.r.winit)))
      else $error("modulo reload wrong");
   restart_load_a: assert property ($rose(q.r.wctl[C_EN])
      |-> q.wcnt == q.r.winit)
      else $error("restart did not reload");
   pp_swap_a: assert property ((w_to && pp && !i_stop_recover) |=> (!q.r.wctl[C_EN]
      && q.r.nctl[C_EN] && q.ncnt == $past(q.r.ninit)))
      else $error("ping-pong handoff wrong");
   wide_irq_a: assert property ((w_to && q.r.wctl[C_CNTM] && !i_stop_recover)
      |=> o_wide_irq ##1 !o_wide_irq)
      else $error("wide timeout interrupt missing");
   ncap_irq_a: assert property ((n_cap && q.r.nctl[C_CAPM] && !i_stop_recover)
      |=> o_narrow_irq)
      else $error("narrow capture interrupt missing");
   div8_hold_a: assert property ((wrun && !demod && q.r.wctl[C_CLK_HI:C_CLK_LO] == DIV8
      && q.pre != 3'h7 && !q.r.sync) |=> q.wcnt == $past(q.wcnt))
      else $error("wide counter stepped off divider");
   demod_pin3_a: assert property ((q.r.shared[S_MODE] && !take_wr && !i_stop_recover)
      |=> o_third_timer_out_pin == $past(i_port_latch[2]))
      else $error("third pin not port in demodulation");
   narrow_swap_a: assert property ((n_to && pp && !i_stop_recover) |=> (!q.r.nctl[C_EN]
      && q.r.wctl[C_EN] && q.wcnt == q.r.winit))
      else $error("narrow ping-pong handoff wrong");
   narrow_tout_irq_a: assert property ((n_to && q.r.nctl[C_CNTM] && !i_stop_recover)
      |=> o_narrow_irq)
      else $error("narrow timeout interrupt missing");
   wide_cap_irq_a: assert property ((w_cap && q.r.wctl[C_CAPM] && !i_stop_recover)
      |=> o_wide_irq)
      else $error("wide capture interrupt missing");
   first_route_a: assert property ((q.r.nctl[C_ROUTE] && !take_wr && !i_stop_recover)
      |=> o_first_timer_out_pin == $past(n.nout))
      else $error("first pin not narrow output");

   pp_swap_c: cover property (w_to && pp);
   wide_cap_c: cover property (w_cap ##[1:50] w_cap);
   narrow_to_c: cover property (n_to && !pp);
   bus_write_c: cover property (take_wr && widx == IDX_WCTL);
   narrow_cap_c: cover property (n_cap && demod);
endmodule : dtd_timer

// ===== verif/dtd_pin_model.sv
`timescale 1ns/1ns
module dtd_pin_model
(
   input  wire logic i_core_clk,
   input  wire logic i_sel_p20,
   input  wire logic i_level,
   output logic      o_first_comparator_pin,
   output logic      o_port_two_pin_zero
);
   logic [3:0] div_cnt = 4'h0;
   logic       noise   = 1'b0;
   // the unselected pin keeps wandering so a wrong input choice shows up
   always @(posedge i_core_clk)
   begin
      div_cnt <= div_cnt + 4'h1;
      if (div_cnt == 4'hf)
         noise <= ~noise;
   end
   assign o_first_comparator_pin = i_sel_p20 ? noise : i_level;
   assign o_port_two_pin_zero    = i_sel_p20 ? i_level : noise;
endmodule : dtd_pin_model

// ===== verif/dual_timer_transmit_demod_test.sv
`timescale 1ns/1ns
module dual_timer_transmit_demod_test
   import dtd_pkg::*;
;
   typedef struct packed {
      logic       wr;
      logic [3:0] idx;
      logic [7:0] val;
   } dtd_row_s;
   localparam dtd_row_s ROWS [14] = '{
      '{1'b0, IDX_SHARED, 8'h00}, '{1'b0, IDX_WCTL, 8'h00}, '{1'b0, IDX_JOINT, 8'h00},
      '{1'b0, IDX_NCTL, 8'h00}, '{1'b1, IDX_SHARED, 8'hff}, '{1'b0, IDX_SHARED, 8'hfc},
      '{1'b1, IDX_SHARED, 8'h00}, '{1'b1, IDX_WCTL, 8'h3f}, '{1'b0, IDX_WCTL, 8'h1f},
      '{1'b1, IDX_WCTL, 8'h00}, '{1'b1, 4'hf, 8'h5a}, '{1'b0, 4'hf, 8'h00},
      '{1'b1, IDX_NINIT, 8'ha5}, '{1'b0, IDX_NINIT, 8'ha5}};
   localparam logic [7:0] EDGES [4] = '{8'h01, 8'h01, 8'h02, 8'h00};
   logic              i_core_clk;
   logic              i_rst_n;
   logic              i_stop_recover;
   logic [DTD_AW-1:0] i_avs_address;
   logic              i_avs_read;
   logic              i_avs_write;
   logic [DTD_DW-1:0] i_avs_writedata;
   logic [3:0]        i_avs_byteenable;
   logic [DTD_DW-1:0] o_avs_readdata;
   logic              o_avs_waitrequest;
   logic              i_first_comparator_pin;
   logic              i_port_two_pin_zero;
   logic [2:0]        i_port_latch;
   logic              o_first_timer_out_pin;
   logic              o_second_timer_out_pin;
   logic              o_third_timer_out_pin;
   logic              o_narrow_irq;
   logic              o_wide_irq;
   logic              sel_p20;
   logic              pin_level;
   logic              seq[$];
   logic [7:0]        rd;
   int                fails = 0;
   int                samples_checked = 0;
   int                wirqs = 0;
   int                nirqs = 0;
   int                w0;
   int                n0;
   time               wlast = 0;
   time               wgap = 0;
   time               t0;

   dtd_timer i_dut (.i_core_clk, .i_rst_n, .i_stop_recover, .i_avs_address, .i_avs_read,
      .i_avs_write, .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest,
      .i_first_comparator_pin, .i_port_two_pin_zero, .i_port_latch, .o_first_timer_out_pin,
      .o_second_timer_out_pin, .o_third_timer_out_pin, .o_narrow_irq, .o_wide_irq);

   dtd_pin_model i_pins (.i_core_clk, .i_sel_p20(sel_p20), .i_level(pin_level),
      .o_first_comparator_pin(i_first_comparator_pin),
      .o_port_two_pin_zero(i_port_two_pin_zero));

   initial
   begin
      i_core_clk = 1'b0;
      forever #5 i_core_clk = ~i_core_clk;
   end

   // interrupt bookkeeping: counts, spacing of wide pulses, order of pulses
   always @(posedge i_core_clk)
   begin
      if ((o_wide_irq | o_narrow_irq) === 1'b1)
         seq.push_back(o_wide_irq);
      if (o_narrow_irq === 1'b1)
         nirqs++;
      if (o_wide_irq === 1'b1)
      begin
         wgap = $time - wlast;
         wlast = $time;
         wirqs++;
      end
   end

   task automatic give_verdict;
      if (fails == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : give_verdict

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         fails++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic bus_op(input logic wr, input logic [3:0] idx, input logic [7:0] val);
      @(posedge i_core_clk);
      i_avs_write     <= wr;
      i_avs_read      <= ~wr;
      i_avs_address   <= {idx, 2'b00};
      i_avs_writedata <= {24'h0, val};
      do
         @(posedge i_core_clk);
      while (o_avs_waitrequest !== 1'b0);
      rd = o_avs_readdata[7:0];
      i_avs_write <= 1'b0;
      i_avs_read  <= 1'b0;
   endtask : bus_op

   task automatic wr_reg(input logic [3:0] idx, input logic [7:0] val);
      bus_op(1'b1, idx, val);
   endtask : wr_reg

   task automatic rd_chk(input logic [3:0] idx, input logic [7:0] exp);
      bus_op(1'b0, idx, 8'h00);
      check(rd, exp);
   endtask : rd_chk

   task automatic wait_irq(input logic wide, input int target);
      int n;
      n = 0;
      while ((wide ? wirqs : nirqs) < target && n < 3000)
      begin
         @(posedge i_core_clk);
         #1;
         n++;
      end
      check(8'((wide ? wirqs : nirqs) >= target), 8'h01);
   endtask : wait_irq

   task automatic pulse;
      @(posedge i_core_clk);
      pin_level <= 1'b1;
      repeat (12) @(posedge i_core_clk);
      pin_level <= 1'b0;
      repeat (12) @(posedge i_core_clk);
   endtask : pulse

   task automatic do_reset;
      @(posedge i_core_clk);
      i_rst_n <= 1'b0;
      repeat (3) @(posedge i_core_clk);
      i_rst_n <= 1'b1;
   endtask : do_reset

   initial
   begin
      #300000;
      fails++;
      give_verdict();
   end

   initial
   begin
      i_rst_n = 1'b0;
      i_stop_recover = 1'b0;
      i_avs_address = '0;
      i_avs_read = 1'b0;
      i_avs_write = 1'b0;
      i_avs_writedata = '0;
      i_avs_byteenable = 4'hf;
      i_port_latch = 3'b000;
      sel_p20 = 1'b0;
      pin_level = 1'b0;
      do_reset();
      foreach (ROWS[k])
         if (ROWS[k].wr)
            wr_reg(ROWS[k].idx, ROWS[k].val);
         else
            rd_chk(ROWS[k].idx, ROWS[k].val);
      for (int p = 0; p < 2; p++)
      begin
         i_port_latch <= p ? 3'b010 : 3'b101;
         repeat (3) @(posedge i_core_clk);
         check(8'(i_port_latch ^ {o_third_timer_out_pin, o_second_timer_out_pin,
            o_first_timer_out_pin}), 8'h00);
      end
      for (int c = 0; c < 4; c++)
      begin
         wr_reg(IDX_SHARED, {2'b01, c[1:0], 4'h0});
         repeat (3) @(posedge i_core_clk);
         check(8'(o_third_timer_out_pin), 8'(c[1]));
      end
      wr_reg(IDX_WINIT_LO, 8'h03);
      wr_reg(IDX_WINIT_HI, 8'h00);
      for (int d = 0; d < 4; d++)
      begin
         wr_reg(IDX_WCTL, {3'b100, d[1:0], 3'b011});
         wait_irq(1'b1, wirqs + 3);
         check(8'(wgap / 10), 8'(4 << d));
         check(8'(o_second_timer_out_pin), 8'h01);
         wr_reg(IDX_WCTL, 8'h20);
      end
      wr_reg(IDX_WCTL, 8'hc2);
      wait_irq(1'b1, wirqs + 1);
      rd_chk(IDX_WCTL, 8'h62);
      wr_reg(IDX_WCTL, 8'h42);
      rd_chk(IDX_WCTL, 8'h62);
      wr_reg(IDX_WCTL, 8'h20);
      rd_chk(IDX_WCTL, 8'h00);
      wr_reg(IDX_WINIT_LO, 8'h28);
      wr_reg(IDX_WCTL, 8'h82);
      repeat (15) @(posedge i_core_clk);
      wr_reg(IDX_WCTL, 8'h02);
      wr_reg(IDX_WCTL, 8'h82);
      t0 = $time;
      wait_irq(1'b1, wirqs + 1);
      check(8'((wlast - t0) / 10 >= 39 && (wlast - t0) / 10 <= 45), 8'h01);
      wr_reg(IDX_WCTL, 8'h20);
      wr_reg(IDX_NINIT, 8'h05);
      wr_reg(IDX_NCTL, 8'h83);
      wait_irq(1'b0, nirqs + 3);
      check(8'(o_first_timer_out_pin), 8'h01);
      rd_chk(IDX_JOINT, 8'h40);
      wr_reg(IDX_JOINT, 8'h80);
      rd_chk(IDX_NCTL, 8'h23);
      rd_chk(IDX_WCTL, 8'h80);
      wr_reg(IDX_JOINT, 8'h00);
      wr_reg(IDX_WINIT_HI, 8'hff);
      for (int e = 0; e < 4; e++)
      begin
         sel_p20 <= e[0];
         wr_reg(IDX_SHARED, {1'b1, e[0], e[1:0], 4'h0});
         repeat (8) @(posedge i_core_clk);
         wr_reg(IDX_NCTL, 8'h84);
         wr_reg(IDX_WCTL, 8'h84);
         n0 = nirqs;
         w0 = wirqs;
         pulse();
         check(8'(wirqs - w0), EDGES[e]);
         check(8'(nirqs - n0), EDGES[e]);
         wr_reg(IDX_JOINT, 8'h00);
      end
      wr_reg(IDX_SHARED, 8'he0);
      wr_reg(IDX_WCTL, 8'hc4);
      w0 = wirqs;
      pulse();
      pulse();
      check(8'(wirqs - w0), 8'h01);
      wr_reg(IDX_JOINT, 8'h00);
      wr_reg(IDX_SHARED, 8'hf4);
      wr_reg(IDX_WCTL, 8'h1e);
      wr_reg(IDX_JOINT, 8'h20);
      @(posedge i_core_clk);
      i_stop_recover <= 1'b1;
      @(posedge i_core_clk);
      i_stop_recover <= 1'b0;
      rd_chk(IDX_SHARED, 8'h30);
      rd_chk(IDX_WCTL, 8'h1c);
      rd_chk(IDX_JOINT, 8'h20);
      wr_reg(IDX_JOINT, 8'h00);
      wr_reg(IDX_NINIT, 8'h03);
      wr_reg(IDX_WINIT_LO, 8'h05);
      wr_reg(IDX_WINIT_HI, 8'h00);
      wr_reg(IDX_SHARED, 8'h04);
      wr_reg(IDX_NCTL, 8'h62);
      wr_reg(IDX_WCTL, 8'h62);
      seq.delete();
      wr_reg(IDX_NCTL, 8'hc2);
      wait_irq(1'b1, wirqs + 2);
      wr_reg(IDX_JOINT, 8'h00);
      check(8'(seq.size() >= 4), 8'h01);
      foreach (seq[k])
         check(8'(seq[k]), 8'(k % 2));
      rd_chk(IDX_NCTL, 8'h62);
      rd_chk(IDX_WCTL, 8'h62);
      i_avs_byteenable <= 4'h0;
      wr_reg(IDX_NINIT, 8'h77);
      i_avs_byteenable <= 4'hf;
      rd_chk(IDX_NINIT, 8'h03);
      do_reset();
      rd_chk(IDX_SHARED, 8'h00);
      rd_chk(IDX_WCTL, 8'h00);
      give_verdict();
   end
endmodule : dual_timer_transmit_demod_test
